// ===== rtl/nvac_ctrl.v
// What this block does
// R1: program memory address uses both address registers
// R2: space select zero targets EEPROM, one program
// R3: start bits set by software, cleared by hardware
// R4: EEPROM writes need write permit; cleared power-on
// R5: write cut by reset sets error flag; the code sets it only for a low-voltage or watchdog reset
// R6: time expiry before self-check sets error flag
// R7: write completion sets done flag; software clears
// R8: unlock port not storage, reads zero
// R9: time field selects 1.25/2.5/5/10 ms limit
// R10: low data holds EEPROM byte or word low
// R11: high data receives upper byte of read
// R12: low address gives eight low bits, resets zero
// R13: high address keeps three bits, rest zero
// R14: software loads address, clears select, sets read
// R15: array access in second slot, latch next clock
// R16: read data held until next operation
// R17: software places two no-ops after read start
// R18: write needs 55h, AAh, then write start
// R19: write start ignored while permit is zero
// R20: write start in program space cleared, no-op
// R21: each byte write erases cell before programming
// R22: write ends on self-check or time expiry
`timescale 1ns/1ps
`include "nvac_defines.vh"
module nvac_ctrl (
   input  wire        clk_i,
   input  wire        sys_rst_i,
   input  wire        por_i,            // power-on reset: clears write permit
   input  wire        lvr_wdt_rst_i,    // low-voltage or watchdog reset event
   // special function register port
   input  wire [7:0]  sfr_addr_i,
   input  wire [7:0]  sfr_wdata_i,
   input  wire        sfr_we_i,
   input  wire        sfr_re_i,
   output reg  [7:0]  sfr_rdata_o,
   // instruction slot suppression toward the core
   output wire        slot_suppress_o,
   // write-done flag lives in the peripheral flag register
   input  wire        done_flag_clr_i,
   output wire        write_done_flag_o,
   // data EEPROM array
   output wire [6:0]  ee_addr_o,
   output wire [7:0]  ee_wdata_o,
   output wire        ee_rd_o,
   input  wire [7:0]  ee_rdata_i,
   output wire        ee_erase_o,
   output wire        ee_prog_o,
   input  wire        ee_verify_ok_i,
   // program memory array
   output wire [10:0] pm_addr_o,
   output wire        pm_rd_o,
   input  wire [15:0] pm_rdata_i
);
   // ==========================================
   // state
   localparam W_IDLE  = 2'b00;
   localparam W_ERASE = 2'b01;
   localparam W_PROG  = 2'b10;

   reg        space_reg;
   reg [1:0]  ptime_reg;
   reg        werr_reg;
   reg        permit_reg;
   reg        wr_reg;
   reg        rd_reg;
   reg [7:0]  dlo_reg;
   reg [7:0]  dhi_reg;
   reg [7:0]  alo_reg;
   reg [2:0]  ahi_reg;
   reg        done_reg;
   reg [1:0]  rcnt_reg;
   reg        rspace_reg;
   reg [1:0]  wst_reg;
   reg [1:0]  wst_next;

   wire       wr_ctl   = sfr_we_i && sfr_addr_i == `NVAC_ADDR_CONTROL;
   wire       wr_unl   = sfr_we_i && sfr_addr_i == `NVAC_ADDR_UNLOCK;
   wire       wr_other = sfr_we_i && !wr_unl;
   wire       armed;
   wire       expired;
   wire       set_wr_req = wr_ctl && sfr_wdata_i[`NVAC_BIT_WR] && !wr_reg;
   wire       set_rd_req = wr_ctl && sfr_wdata_i[`NVAC_BIT_RD] && !rd_reg && !wr_reg;
   wire       space_new  = wr_ctl ? sfr_wdata_i[`NVAC_BIT_SPACE] : space_reg;
   // write accepted only when armed, permitted and targeting EEPROM
   wire       wr_go = set_wr_req && armed && permit_reg && !space_new;  // see R18 see R19 see R4 see R20
   wire       verify_done = (wst_reg == W_PROG) && ee_verify_ok_i;
   wire       wr_end = (wst_reg == W_PROG) && (ee_verify_ok_i || expired); // see R22
   wire       rd_fire = rd_reg && rcnt_reg == `NVAC_RD_SLOT_CYC;

   // ==========================================
   // unlock sequence and programming timer
   nvac_unlock u_unlock (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .wr_unlock_i (wr_unl),
      .wr_other_i  (wr_other && !wr_ctl),
      .wdata_i     (sfr_wdata_i),
      .consume_i   (wr_ctl),
      .armed_o     (armed)
   );

   nvac_wtimer u_wtimer (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (wr_go),
      .run_i     (wst_reg != W_IDLE),
      .sel_i     (ptime_reg),
      .expired_o (expired)
   );

   // ==========================================
   // write sequencer: erase first, then program until verify or timeout
   always @* begin
      wst_next = wst_reg;
      case (wst_reg)
         W_IDLE:  if (wr_go) wst_next = W_ERASE;
         W_ERASE: wst_next = expired ? W_IDLE : W_PROG;   // see R21
         W_PROG:  if (wr_end) wst_next = W_IDLE;
         default: wst_next = W_IDLE;
      endcase
   end

   // ==========================================
   // control register and write flow
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         space_reg  <= 1'b0;                       // see R2
         ptime_reg  <= 2'b00;
         wr_reg     <= 1'b0;
         rd_reg     <= 1'b0;
         wst_reg    <= W_IDLE;
         rcnt_reg   <= 2'b00;
         rspace_reg <= 1'b0;
         // a write cut off by a low-voltage or watchdog reset leaves the error flag up
         if (lvr_wdt_rst_i && wr_reg) werr_reg <= 1'b1; // see R5
      end else begin
         wst_reg <= wst_next;
         if (wr_ctl) begin
            space_reg <= sfr_wdata_i[`NVAC_BIT_SPACE];
            ptime_reg <= sfr_wdata_i[`NVAC_BIT_TIME_HI:`NVAC_BIT_TIME_LO];
         end
         // write start: software can only set; program space drops it at once
         if (wr_go) begin
            wr_reg <= 1'b1;                        // see R3
         end else if (wr_end || (wst_reg == W_ERASE && expired)) begin
            wr_reg <= 1'b0;                        // see R3 see R22
         end
         // error flag: hardware set wins over a software write
         if (wr_end) begin
            werr_reg <= !verify_done;              // see R6
         end else if (wr_ctl && !wr_reg) begin
            werr_reg <= sfr_wdata_i[`NVAC_BIT_WERR];
         end
         // read start: counts instruction slots before the access
         if (set_rd_req) begin
            rd_reg     <= 1'b1;                    // see R3
            rcnt_reg   <= 2'b01;
            rspace_reg <= space_new;
         end else if (rd_reg) begin
            if (rd_fire) rd_reg <= 1'b0;
            else rcnt_reg <= rcnt_reg + 2'b01;
         end
      end
   end

   // ==========================================
   // write permit: set and cleared by control writes; of the resets only power-on clears it, a plain reset keeps it
   always @(posedge clk_i) begin
      if (por_i) begin
         permit_reg <= 1'b0;                       // see R4
      end else if (wr_ctl) begin
         permit_reg <= sfr_wdata_i[`NVAC_BIT_PERMIT];
      end
   end

   // ==========================================
   // write-done flag: set wins over software clear
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         done_reg <= 1'b0;
      end else if (wr_end || (wst_reg == W_ERASE && expired)) begin
         done_reg <= 1'b1;                         // see R7
      end else if (done_flag_clr_i) begin
         done_reg <= 1'b0;
      end
   end

   // ==========================================
   // address and data registers
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         alo_reg <= 8'h00;                         // see R12
         ahi_reg <= 3'h0;
      end else if (sfr_we_i) begin
         if (sfr_addr_i == `NVAC_ADDR_ADDR_LO) alo_reg <= sfr_wdata_i;
         if (sfr_addr_i == `NVAC_ADDR_ADDR_HI) ahi_reg <= sfr_wdata_i[2:0]; // see R13
      end
   end

   // data registers have no reset value; they hold until the next access
   always @(posedge clk_i) begin
      if (rd_fire) begin
         if (rspace_reg) begin
            dlo_reg <= pm_rdata_i[7:0];            // see R10 see R15
            dhi_reg <= pm_rdata_i[15:8];           // see R11
         end else begin
            dlo_reg <= ee_rdata_i;                 // see R10 see R16
            dhi_reg <= 8'h00;
         end
      end else if (sfr_we_i && sfr_addr_i == `NVAC_ADDR_DATA_LO) begin
         dlo_reg <= sfr_wdata_i;
      end else if (sfr_we_i && sfr_addr_i == `NVAC_ADDR_DATA_HI) begin
         dhi_reg <= sfr_wdata_i;
      end
   end

   // ==========================================
   // read mux; unlock port and unused bits return zero
   always @* begin
      sfr_rdata_o = 8'h00;
      if (sfr_re_i) begin
         case (sfr_addr_i)
            `NVAC_ADDR_CONTROL: sfr_rdata_o = {space_reg, 1'b0, ptime_reg, werr_reg, permit_reg, wr_reg, rd_reg};
            `NVAC_ADDR_UNLOCK:  sfr_rdata_o = 8'h00;   // see R8
            `NVAC_ADDR_DATA_LO: sfr_rdata_o = dlo_reg;
            `NVAC_ADDR_DATA_HI: sfr_rdata_o = dhi_reg;
            `NVAC_ADDR_ADDR_LO: sfr_rdata_o = alo_reg;
            `NVAC_ADDR_ADDR_HI: sfr_rdata_o = {5'h00, ahi_reg} & `NVAC_ADDR_HI_MASK; // see R13
            default:            sfr_rdata_o = 8'h00;
         endcase
      end
   end

   // ==========================================
   // array side
   assign ee_addr_o         = alo_reg[6:0];           // see R1
   assign pm_addr_o         = {ahi_reg, alo_reg};     // see R1
   assign ee_rd_o           = rd_fire && !rspace_reg;
   assign pm_rd_o           = rd_fire && rspace_reg;
   assign ee_wdata_o        = dlo_reg;
   assign ee_erase_o        = (wst_reg == W_ERASE);   // see R21
   assign ee_prog_o         = (wst_reg == W_PROG);
   assign slot_suppress_o   = rd_fire;                // see R15 see R17
   assign write_done_flag_o = done_reg;
endmodule // nvac_ctrl

// ===== rtl/nvac_defines.vh
`ifndef NVAC_DEFINES_VH
`define NVAC_DEFINES_VH
// ==========================================
// register addresses on the special function bus
`define NVAC_ADDR_CONTROL   8'h8C
`define NVAC_ADDR_UNLOCK    8'h8D
`define NVAC_ADDR_DATA_LO   8'h8E
`define NVAC_ADDR_DATA_HI   8'h8F
`define NVAC_ADDR_ADDR_LO   8'h90
`define NVAC_ADDR_ADDR_HI   8'h96
// ==========================================
// control register fields
`define NVAC_BIT_SPACE      7
`define NVAC_BIT_TIME_HI    5
`define NVAC_BIT_TIME_LO    4
`define NVAC_BIT_WERR       3
`define NVAC_BIT_PERMIT     2
`define NVAC_BIT_WR         1
`define NVAC_BIT_RD         0
`define NVAC_ADDR_HI_MASK   8'h07
// ==========================================
// unlock key bytes
`define NVAC_KEY_FIRST      8'h55
`define NVAC_KEY_SECOND     8'hAA
// ==========================================
// timing: clock 250 MHz, times in microseconds
`define NVAC_CLK_MHZ        250
`define NVAC_TIME0_US       1250
`define NVAC_TIME1_US       2500
`define NVAC_TIME2_US       5000
`define NVAC_TIME3_US       10000
// cycle counts sized to the timer width so the limit lookup drops no bits
`define NVAC_CYC0           22'h04C4B4
`define NVAC_CYC1           22'h098968
`define NVAC_CYC2           22'h1312D0
`define NVAC_CYC3           22'h2625A0
// read pipeline: access in second slot, latch one clock later
`define NVAC_RD_SLOT_CYC    2
`define NVAC_TMR_W          22
`endif

// ===== rtl/nvac_unlock.v
`timescale 1ns/1ps
`include "nvac_defines.vh"
// ==========================================
// unlock sequencer: 55h then AAh to the unlock port arms one write start
module nvac_unlock (
   input  wire       clk_i,
   input  wire       sys_rst_i,
   input  wire       wr_unlock_i,   // write strobe to unlock port
   input  wire       wr_other_i,    // any bus write other than to the unlock or control register breaks the chain
   input  wire [7:0] wdata_i,
   input  wire       consume_i,     // any control register write uses up the arm
   output wire       armed_o
);
   reg [1:0] st_reg;
   reg [1:0] st_next;
   localparam S_IDLE = 2'b00;
   localparam S_GOT1 = 2'b01;
   localparam S_ARM  = 2'b10;

   // ==========================================
   // sequence tracker
   always @* begin
      st_next = st_reg;
      case (st_reg)
         S_IDLE: begin
            if (wr_unlock_i && wdata_i == `NVAC_KEY_FIRST) st_next = S_GOT1;
         end
         S_GOT1: begin
            if (wr_unlock_i) st_next = (wdata_i == `NVAC_KEY_SECOND) ? S_ARM : S_IDLE;
            else if (wr_other_i) st_next = S_IDLE;
         end
         S_ARM: begin
            // the arm survives only until the very next write
            if (consume_i || wr_other_i || wr_unlock_i) st_next = S_IDLE;
         end
         default: st_next = S_IDLE;
      endcase
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_reg <= S_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign armed_o = (st_reg == S_ARM); // see R18
endmodule // nvac_unlock

// ===== rtl/nvac_wtimer.v
`timescale 1ns/1ps
`include "nvac_defines.vh"
// ==========================================
// programming-time limit counter
module nvac_wtimer (
   input  wire       clk_i,
   input  wire       sys_rst_i,
   input  wire       start_i,     // load the selected limit minus one
   input  wire       run_i,
   input  wire [1:0] sel_i,
   output wire       expired_o
);
   reg [`NVAC_TMR_W-1:0] cnt_reg;
   reg [`NVAC_TMR_W-1:0] lim;

   // limit lookup for the two-bit time field
   always @* begin
      case (sel_i)
         2'b00:   lim = `NVAC_CYC0; // see R9
         2'b01:   lim = `NVAC_CYC1;
         2'b10:   lim = `NVAC_CYC2;
         default: lim = `NVAC_CYC3;
      endcase
   end

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_reg <= {`NVAC_TMR_W{1'b0}};
      end else if (start_i) begin
         cnt_reg <= lim - 1'b1;
      end else if (run_i && cnt_reg != {`NVAC_TMR_W{1'b0}}) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign expired_o = run_i && (cnt_reg == {`NVAC_TMR_W{1'b0}});
endmodule // nvac_wtimer

// ===== dv/nvac_ctrl_chk.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the nonvolatile access controller
module nvac_ctrl_chk (
   input logic        clk_i,
   input logic        sys_rst_i,
   input logic [7:0]  sfr_addr_i,
   input logic [7:0]  sfr_wdata_i,
   input logic        sfr_we_i,
   input logic        sfr_re_i,
   input logic [7:0]  sfr_rdata_o,
   input logic        slot_suppress_o,
   input logic        done_flag_clr_i,
   input logic        write_done_flag_o,
   input logic [6:0]  ee_addr_o,
   input logic        ee_rd_o,
   input logic        ee_erase_o,
   input logic        ee_prog_o,
   input logic        ee_verify_ok_i,
   input logic [10:0] pm_addr_o,
   input logic        pm_rd_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ==========================================
   // read start request; guarded against a running write, which refuses it
   sequence s_rd_req(logic sp);
      sfr_we_i && sfr_addr_i == 8'h8C && sfr_wdata_i[0] && sfr_wdata_i[7] == sp && !ee_erase_o && !ee_prog_o;
   endsequence
   a_ee_read_start: assert property (s_rd_req(1'b0) |-> ##2 (ee_rd_o && !pm_rd_o))
      else $error("eeprom read not issued in its slot");
   a_pm_read_start: assert property (s_rd_req(1'b1) |-> ##2 (pm_rd_o && !ee_rd_o))
      else $error("program read not issued in its slot");
   a_read_cause: assert property ((ee_rd_o || pm_rd_o) |-> $past(sfr_we_i && sfr_addr_i == 8'h8C && sfr_wdata_i[0], 2))
      else $error("array read without a read start");
   a_slot_drop: assert property ((ee_rd_o || pm_rd_o) |-> slot_suppress_o)
      else $error("instruction slot not dropped during access");
   a_unlock_zero: assert property (sfr_re_i && sfr_addr_i == 8'h8D |-> sfr_rdata_o == 8'h00)
      else $error("unlock port read not zero");
   a_addr_hi_bits: assert property (sfr_re_i && sfr_addr_i == 8'h96 |-> sfr_rdata_o[7:3] == 5'h00)
      else $error("high address upper bits not zero");
   a_addr_shared: assert property (pm_rd_o |-> pm_addr_o[6:0] == ee_addr_o)
      else $error("low address not shared by both spaces");
   a_erase_first: assert property ($rose(ee_prog_o) |-> $past(ee_erase_o))
      else $error("programming without erase");
   a_verify_ends: assert property (ee_prog_o && ee_verify_ok_i |=> !ee_prog_o ##0 write_done_flag_o)
      else $error("write did not end on self-check");
   a_done_sticky: assert property (write_done_flag_o && !done_flag_clr_i |=> write_done_flag_o)
      else $error("done flag cleared by hardware");
endmodule // nvac_ctrl_chk

bind nvac_ctrl nvac_ctrl_chk i_nvac_ctrl_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wdata_i(sfr_wdata_i), .sfr_we_i(sfr_we_i), .sfr_re_i(sfr_re_i), .sfr_rdata_o(sfr_rdata_o),
   .slot_suppress_o(slot_suppress_o), .done_flag_clr_i(done_flag_clr_i), .write_done_flag_o(write_done_flag_o),
   .ee_addr_o(ee_addr_o), .ee_rd_o(ee_rd_o), .ee_erase_o(ee_erase_o), .ee_prog_o(ee_prog_o),
   .ee_verify_ok_i(ee_verify_ok_i), .pm_addr_o(pm_addr_o), .pm_rd_o(pm_rd_o));

// ===== dv/tb_nvac_ctrl.sv
`timescale 1ns/1ps
module tb_nvac_ctrl;
   // ==========================================
   // stimulus and observed signals
   logic        clk_i, sys_rst_i, por_i, lvr_wdt_rst_i, sfr_we_i, sfr_re_i, done_flag_clr_i, ee_verify_ok_i;
   logic [7:0]  sfr_addr_i, sfr_wdata_i, ee_rdata_i, sfr_rdata_o, ee_wdata_o, v;
   logic [15:0] pm_rdata_i;
   logic [6:0]  ee_addr_o;
   logic [10:0] pm_addr_o;
   logic        slot_suppress_o, write_done_flag_o, ee_rd_o, ee_erase_o, ee_prog_o, pm_rd_o;
   int          n_fail = 0;
   int          tests_run = 0;

   nvac_ctrl i_nvac_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i), .lvr_wdt_rst_i(lvr_wdt_rst_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_we_i(sfr_we_i), .sfr_re_i(sfr_re_i),
      .sfr_rdata_o(sfr_rdata_o), .slot_suppress_o(slot_suppress_o), .done_flag_clr_i(done_flag_clr_i),
      .write_done_flag_o(write_done_flag_o), .ee_addr_o(ee_addr_o), .ee_wdata_o(ee_wdata_o), .ee_rd_o(ee_rd_o),
      .ee_rdata_i(ee_rdata_i), .ee_erase_o(ee_erase_o), .ee_prog_o(ee_prog_o), .ee_verify_ok_i(ee_verify_ok_i),
      .pm_addr_o(pm_addr_o), .pm_rd_o(pm_rd_o), .pm_rdata_i(pm_rdata_i));

   // ==========================================
   // 250 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // ==========================================
   // shared helpers
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_we_i <= 1'b1;
      @(posedge clk_i);
      sfr_we_i <= 1'b0;
   endtask
   // read data is taken at the edge where the request still stands
   task rd(input logic [7:0] a);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_re_i <= 1'b1;
      @(posedge clk_i);
      v = sfr_rdata_o;
      sfr_re_i <= 1'b0;
   endtask
   task unlock;
      wr(8'h8D, 8'h55);
      wr(8'h8D, 8'hAA);
   endtask
   // bounded wait: 0 array read, 1 erase, 2 program, 3 program over
   task wait_on(input int k);
      int n;
      n = 0;
      #1;
      while (!(k == 0 ? (ee_rd_o | pm_rd_o) : k == 1 ? ee_erase_o : k == 2 ? ee_prog_o : !ee_prog_o) && n < 64) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("wait", 0, n >= 64);
   endtask
   task no_write;
      repeat (6) begin
         @(posedge clk_i);
         #1 chk("erase", 0, ee_erase_o);
      end
      rd(8'h8C);
      chk("start bit", 0, v[1]);
   endtask

   // ==========================================
   // scenarios
   task t_reset;
      rd(8'h8C);
      chk("ctrl", 0, v & 8'hF7);
      rd(8'h90);
      chk("addr lo", 0, v);
      rd(8'h96);
      chk("addr hi", 0, v);
      rd(8'h8D);
      chk("unlock", 0, v);
   endtask
   task t_ee_read;
      ee_rdata_i <= 8'hA5;
      wr(8'h90, 8'h05);
      wr(8'h8C, 8'h01);
      wait_on(0);
      chk("ee addr", 7'h05, ee_addr_o);
      chk("ee rd", 1, ee_rd_o);
      @(posedge clk_i);
      ee_rdata_i <= 8'h3C;
      rd(8'h8E);
      chk("data lo", 8'hA5, v);
      rd(8'h8F);
      chk("data hi", 0, v);
      rd(8'h8C);
      chk("rd bit", 0, v[0]);
   endtask
   task t_pm_read;
      wr(8'h96, 8'hFF);
      rd(8'h96);
      chk("addr hi", 8'h07, v);
      wr(8'h90, 8'h34);
      pm_rdata_i <= 16'hBEEF;
      wr(8'h8C, 8'h81);
      wait_on(0);
      chk("pm addr", 11'h734, pm_addr_o);
      @(posedge clk_i);
      pm_rdata_i <= 16'h0000;
      rd(8'h8E);
      chk("word lo", 8'hEF, v);
      rd(8'h8F);
      chk("word hi", 8'hBE, v);
   endtask
   task t_refused;
      wr(8'h8C, 8'h04);
      wr(8'h8C, 8'h06);
      no_write;
      unlock;
      wr(8'h8C, 8'h86);
      no_write;
      wr(8'h8C, 8'h00);
      unlock;
      wr(8'h8C, 8'h02);
      no_write;
   endtask
   task t_write;
      ee_verify_ok_i <= 1'b0;
      wr(8'h90, 8'h11);
      wr(8'h8E, 8'h5A);
      wr(8'h8C, 8'h04);
      unlock;
      wr(8'h8C, 8'h06);
      wait_on(1);
      chk("ee wdata", 8'h5A, ee_wdata_o);
      wait_on(2);
      repeat (3) @(posedge clk_i);
      ee_verify_ok_i <= 1'b1;
      wait_on(3);
      @(posedge clk_i);
      ee_verify_ok_i <= 1'b0;
      chk("done", 1, write_done_flag_o);
      rd(8'h8C);
      chk("end bits", 8'h04, v & 8'h0E);
      @(posedge clk_i);
      done_flag_clr_i <= 1'b1;
      @(posedge clk_i);
      done_flag_clr_i <= 1'b0;
      #1 chk("done clr", 0, write_done_flag_o);
   endtask
   // a reset from the supervisor cuts a write short
   task t_cut;
      unlock;
      wr(8'h8C, 8'h06);
      wait_on(2);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      lvr_wdt_rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      lvr_wdt_rst_i <= 1'b0;
      rd(8'h8C);
      chk("error", 1, v[3]);
      chk("permit", 1, v[2]);
   endtask

   task results;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #200000;
      n_fail++;
      results;
   end

   // ==========================================
   // main sequence: power-on reset for 20 cycles, then the scenarios
   initial begin
      {sys_rst_i, por_i} = 2'b11;
      {lvr_wdt_rst_i, sfr_we_i, sfr_re_i, done_flag_clr_i, ee_verify_ok_i} = 5'h00;
      {sfr_addr_i, sfr_wdata_i, ee_rdata_i} = 24'h000000;
      pm_rdata_i = 16'h0000;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      por_i <= 1'b0;
      t_reset;
      t_ee_read;
      t_pm_read;
      t_refused;
      t_write;
      t_cut;
      results;
   end
endmodule // tb_nvac_ctrl
